// ### rtl/p1pbc_top.sv
// Port 1 PHY basic control and status registers with their shared views.
`timescale 1ns/1ps
`default_nettype none
module p1pbc_top #(
  parameter int RESTART_HOLD = p1pbc_pkg::RESTART_HOLD_CYC
) (
  // Clock, reset and enable.
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   ce,
  // Host register access.
  input  wire p1pbc_pkg::p1pbc_req_t  host_req,
  output logic [15:0]                 host_rdata_ff,
  output logic                        host_rvalid_ff,
  // PHY core status.
  input  wire p1pbc_pkg::p1pbc_phy_t  phy_stat,
  // PHY core control.
  output p1pbc_pkg::p1pbc_ctrl_t      phy_ctrl,
  output logic                        autoneg_restart,
  output logic                        eff_speed_100_ff,
  output logic                        eff_duplex_full_ff,
  output logic                        tx_enable_ff
);

  // ****************************************************************
  // Parameter checks.
  // ****************************************************************
  if (RESTART_HOLD < 1 || RESTART_HOLD > 8)
  begin : g_bad_hold
    $error("RESTART_HOLD must lie between 1 and 8");
  end

  // ****************************************************************
  // Reset release.
  // ****************************************************************
  logic rst_meta_ff;
  logic rst_sync_n;

  // Assertion is immediate, release passes two flops to avoid a racy edge.
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_n  <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_n  <= rst_meta_ff;
    end
  end

  // ****************************************************************
  // Address decode and write data merge.
  // ****************************************************************
  p1pbc_pkg::p1pbc_ctrl_t ctrl_ff;
  logic        hit_bc;
  logic        hit_bs;
  logic        hit_c4;
  logic        hit_cw;
  logic        hit_sw;
  logic        restart_busy;
  logic        restart_start;
  logic [15:0] view_bc;
  logic [15:0] view_bs;
  logic [15:0] view_c4;
  logic [15:0] view_cw;
  logic [15:0] view_sw;
  logic [15:0] merged_bc;
  logic [15:0] merged_c4;
  logic [15:0] merged_cw;
  logic [15:0] merged_sw;
  logic        wr_go;

  assign wr_go  = ce && host_req.wr;
  assign hit_bc = (host_req.addr == p1pbc_pkg::OFS_BASIC_CTRL);
  assign hit_bs = (host_req.addr == p1pbc_pkg::OFS_BASIC_STAT);
  assign hit_c4 = (host_req.addr == p1pbc_pkg::OFS_CTRL_FOUR);
  assign hit_cw = (host_req.addr == p1pbc_pkg::OFS_CTRL_WORD);
  assign hit_sw = (host_req.addr == p1pbc_pkg::OFS_STATUS_WORD);

  // Views of the one control store; unsupported positions stay zero.
  always_comb
  begin
    view_bc = 16'h0000;
    view_bc[p1pbc_pkg::BC_LOOP]    = ctrl_ff.loopback;
    view_bc[p1pbc_pkg::BC_SPEED]   = ctrl_ff.speed_100;
    view_bc[p1pbc_pkg::BC_AUTONEG] = ctrl_ff.autoneg_en;
    view_bc[p1pbc_pkg::BC_PDOWN]   = ctrl_ff.power_down;
    view_bc[p1pbc_pkg::BC_RESTART] = restart_busy;
    view_bc[p1pbc_pkg::BC_DUPLEX]  = ctrl_ff.duplex_full;
    view_bc[p1pbc_pkg::BC_XVAR]    = ctrl_ff.xover_std;
    view_bc[p1pbc_pkg::BC_XFORCE]  = ctrl_ff.xover_force;
    view_bc[p1pbc_pkg::BC_XOFF]    = ctrl_ff.xover_off;
    view_bc[p1pbc_pkg::BC_RSV2]    = ctrl_ff.rsv2;
    view_bc[p1pbc_pkg::BC_TXOFF]   = ctrl_ff.tx_off;
    view_bc[p1pbc_pkg::BC_RSV0]    = ctrl_ff.rsv0;
    view_c4 = 16'h0000;
    view_c4[p1pbc_pkg::C4_LOOP]    = ctrl_ff.loopback;
    view_c4[p1pbc_pkg::C4_AUTONEG] = ctrl_ff.autoneg_en;
    view_c4[p1pbc_pkg::C4_SPEED]   = ctrl_ff.speed_100;
    view_c4[p1pbc_pkg::C4_XFORCE]  = ctrl_ff.xover_force;
    view_c4[p1pbc_pkg::C4_XOFF]    = ctrl_ff.xover_off;
    view_c4[p1pbc_pkg::C4_PDOWN]   = ctrl_ff.power_down;
    view_c4[p1pbc_pkg::C4_RSV2]    = ctrl_ff.rsv2;
    view_c4[p1pbc_pkg::C4_RESTART] = restart_busy;
    view_c4[p1pbc_pkg::C4_TXOFF]   = ctrl_ff.tx_off;
    view_cw = 16'h0000;
    view_cw[p1pbc_pkg::CW_DUPLEX]  = ctrl_ff.duplex_full;
    view_sw = 16'h0000;
    view_sw[p1pbc_pkg::SW_XVAR]    = ctrl_ff.xover_std;
    view_sw[p1pbc_pkg::SW_DONE]    = phy_stat.autoneg_done;
    view_sw[p1pbc_pkg::SW_LINK]    = phy_stat.link_up;
  end

  // Status word: fixed capabilities plus live negotiation and link state.
  always_comb
  begin
    view_bs = p1pbc_pkg::BS_FIXED_CAPS;
    view_bs[p1pbc_pkg::BS_DONE] = phy_stat.autoneg_done;
    view_bs[p1pbc_pkg::BS_LINK] = phy_stat.link_up;
  end

  p1pbc_lane_merge #(.W(16)) u_merge_bc (
    .cur    (view_bc),
    .wdata  (host_req.wdata),
    .be     (host_req.be),
    .merged (merged_bc)
  );

  p1pbc_lane_merge #(.W(16)) u_merge_c4 (
    .cur    (view_c4),
    .wdata  (host_req.wdata),
    .be     (host_req.be),
    .merged (merged_c4)
  );

  p1pbc_lane_merge #(.W(16)) u_merge_cw (
    .cur    (view_cw),
    .wdata  (host_req.wdata),
    .be     (host_req.be),
    .merged (merged_cw)
  );

  p1pbc_lane_merge #(.W(16)) u_merge_sw (
    .cur    (view_sw),
    .wdata  (host_req.wdata),
    .be     (host_req.be),
    .merged (merged_sw)
  );

  // ****************************************************************
  // Control store.
  // ****************************************************************
  // Each view writes its own fields of the same flops, so a later read of any view holding the field sees it.
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      ctrl_ff <= '{loopback: 1'b0, speed_100: 1'b1, autoneg_en: 1'b1,
                   power_down: 1'b0, duplex_full: 1'b1, xover_std: 1'b1,
                   xover_force: 1'b0, xover_off: 1'b0, tx_off: 1'b0,
                   rsv2: 1'b0, rsv0: 1'b0};
    else if (wr_go && hit_bc)
    begin
      ctrl_ff.loopback    <= merged_bc[p1pbc_pkg::BC_LOOP];
      ctrl_ff.speed_100   <= merged_bc[p1pbc_pkg::BC_SPEED];
      ctrl_ff.autoneg_en  <= merged_bc[p1pbc_pkg::BC_AUTONEG];
      ctrl_ff.power_down  <= merged_bc[p1pbc_pkg::BC_PDOWN];
      ctrl_ff.duplex_full <= merged_bc[p1pbc_pkg::BC_DUPLEX];
      ctrl_ff.xover_std   <= merged_bc[p1pbc_pkg::BC_XVAR];
      ctrl_ff.xover_force <= merged_bc[p1pbc_pkg::BC_XFORCE];
      ctrl_ff.xover_off   <= merged_bc[p1pbc_pkg::BC_XOFF];
      ctrl_ff.rsv2        <= merged_bc[p1pbc_pkg::BC_RSV2];
      ctrl_ff.tx_off      <= merged_bc[p1pbc_pkg::BC_TXOFF];
      ctrl_ff.rsv0        <= merged_bc[p1pbc_pkg::BC_RSV0];
    end
    else if (wr_go && hit_c4)
    begin
      ctrl_ff.loopback    <= merged_c4[p1pbc_pkg::C4_LOOP];
      ctrl_ff.speed_100   <= merged_c4[p1pbc_pkg::C4_SPEED];
      ctrl_ff.autoneg_en  <= merged_c4[p1pbc_pkg::C4_AUTONEG];
      ctrl_ff.power_down  <= merged_c4[p1pbc_pkg::C4_PDOWN];
      ctrl_ff.xover_force <= merged_c4[p1pbc_pkg::C4_XFORCE];
      ctrl_ff.xover_off   <= merged_c4[p1pbc_pkg::C4_XOFF];
      ctrl_ff.rsv2        <= merged_c4[p1pbc_pkg::C4_RSV2];
      ctrl_ff.tx_off      <= merged_c4[p1pbc_pkg::C4_TXOFF];
    end
    else if (wr_go && hit_cw)
      ctrl_ff.duplex_full <= merged_cw[p1pbc_pkg::CW_DUPLEX];
    else if (wr_go && hit_sw)
      ctrl_ff.xover_std   <= merged_sw[p1pbc_pkg::SW_XVAR];
  end

  // ****************************************************************
  // Negotiation restart.
  // ****************************************************************
  // A one written through either view starts one restart; busy reads back.
  assign restart_start = wr_go &&
    ((hit_bc && host_req.be[1] && host_req.wdata[p1pbc_pkg::BC_RESTART]) ||
     (hit_c4 && host_req.be[1] && host_req.wdata[p1pbc_pkg::C4_RESTART]));

  p1pbc_restart_seq #(.HOLD_CYC(RESTART_HOLD)) u_restart (
    .clk_sys (clk_sys),
    .rst_n   (rst_sync_n),
    .ce      (ce),
    .start   (restart_start),
    .busy    (restart_busy),
    .pulse   (autoneg_restart)
  );

  // ****************************************************************
  // Effective operating mode.
  // ****************************************************************
  // Forced values rule when negotiation is off; duplex also on failure.
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      eff_speed_100_ff   <= 1'b1;
      eff_duplex_full_ff <= 1'b1;
    end
    else if (ce)
    begin
      eff_speed_100_ff   <= ctrl_ff.autoneg_en ? phy_stat.neg_speed_100
                                               : ctrl_ff.speed_100;
      eff_duplex_full_ff <= (!ctrl_ff.autoneg_en || phy_stat.autoneg_fail)
                            ? ctrl_ff.duplex_full
                            : phy_stat.neg_duplex_full;
    end
  end

  // Transmitter runs only when neither disabled nor powered down.
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      tx_enable_ff <= 1'b0;
    else if (ce)
      tx_enable_ff <= !ctrl_ff.tx_off && !ctrl_ff.power_down;
  end

  // Loopback, crossover and power controls go straight to the PHY.
  assign phy_ctrl = ctrl_ff;

  // ****************************************************************
  // Read path.
  // ****************************************************************
  // Read data is held until the next read; unmapped offsets return zero.
  always_ff @(posedge clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      host_rdata_ff  <= 16'h0000;
      host_rvalid_ff <= 1'b0;
    end
    else if (ce)
    begin
      host_rvalid_ff <= host_req.rd;
      if (host_req.rd)
      begin
        unique case (1'b1)
          hit_bc:  host_rdata_ff <= view_bc;
          hit_bs:  host_rdata_ff <= view_bs;
          hit_c4:  host_rdata_ff <= view_c4;
          hit_cw:  host_rdata_ff <= view_cw;
          hit_sw:  host_rdata_ff <= view_sw;
          default: host_rdata_ff <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  sequence s_restart_write;
    restart_start && !restart_busy;
  endsequence

  sequence s_restart_pulse;
    autoneg_restart ##1 !autoneg_restart;
  endsequence

  chk_restart_pulse_once: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n || !ce)
    s_restart_write |=> s_restart_pulse)
    else $error("restart did not give a single pulse");

  chk_restart_self_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n || !ce)
    $rose(restart_busy) |-> ##[1:9] !restart_busy)
    else $error("restart bit did not clear itself");

  chk_status_fixed_bits: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (ce && host_req.rd && hit_bs) |=>
      host_rdata_ff[15:11] == 5'b01111 && host_rdata_ff[3] == 1'b1 &&
      host_rdata_ff[1:0] == 2'b00 && host_rdata_ff[6] == 1'b0)
    else $error("status capability bits wrong");

  chk_status_live_bits: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (ce && host_req.rd && hit_bs) |=>
      host_rdata_ff[2] == $past(phy_stat.link_up) &&
      host_rdata_ff[5] == $past(phy_stat.autoneg_done))
    else $error("link or completion status wrong");

  chk_ctrl_ro_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (ce && host_req.rd && hit_bc) |=>
      host_rdata_ff[15] == 1'b0 && host_rdata_ff[10] == 1'b0 &&
      host_rdata_ff[7] == 1'b0)
    else $error("unsupported control bits not zero");

  chk_speed_forced: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n || !ce)
    !ctrl_ff.autoneg_en |=> eff_speed_100_ff == $past(ctrl_ff.speed_100))
    else $error("forced speed not applied");

  chk_duplex_fallback: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n || !ce)
    (!ctrl_ff.autoneg_en || phy_stat.autoneg_fail) |=>
      eff_duplex_full_ff == $past(ctrl_ff.duplex_full))
    else $error("forced duplex not applied");

  chk_shared_loopback: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (wr_go && hit_c4 && host_req.be[1]) |=>
      phy_ctrl.loopback == $past(host_req.wdata[p1pbc_pkg::C4_LOOP]))
    else $error("shared loopback bit not stored");

  chk_tx_gate: assert property (
    @(posedge clk_sys) disable iff (!rst_sync_n || !ce)
    (ctrl_ff.tx_off || ctrl_ff.power_down) |=> !tx_enable_ff)
    else $error("transmitter left on");

endmodule
`default_nettype wire

// ### pkg/p1pbc_pkg.sv
// Constants, field positions and carrier types for the port 1 PHY basic control block.
`default_nettype none
package p1pbc_pkg;

  // ****************************************************************
  // Host interface geometry and register offsets.
  // ****************************************************************
  localparam int          ADDR_W             = 8;
  localparam int          DATA_W             = 16;
  localparam logic [7:0]  OFS_BASIC_CTRL     = 8'h4c;
  localparam logic [7:0]  OFS_BASIC_STAT     = 8'h4e;
  localparam logic [7:0]  OFS_CTRL_FOUR      = 8'hc0;
  localparam logic [7:0]  OFS_CTRL_WORD      = 8'hc2;
  localparam logic [7:0]  OFS_STATUS_WORD    = 8'hc4;

  // ****************************************************************
  // Bit positions in the basic control word.
  // ****************************************************************
  localparam int BC_LOOP    = 14;
  localparam int BC_SPEED   = 13;
  localparam int BC_AUTONEG = 12;
  localparam int BC_PDOWN   = 11;
  localparam int BC_RESTART = 9;
  localparam int BC_DUPLEX  = 8;
  localparam int BC_XVAR    = 5;
  localparam int BC_XFORCE  = 4;
  localparam int BC_XOFF    = 3;
  localparam int BC_RSV2    = 2;
  localparam int BC_TXOFF   = 1;
  localparam int BC_RSV0    = 0;

  // ****************************************************************
  // Bit positions in the shared views and the basic status word.
  // ****************************************************************
  localparam int C4_LOOP    = 8;
  localparam int C4_AUTONEG = 7;
  localparam int C4_SPEED   = 6;
  localparam int C4_XFORCE  = 9;
  localparam int C4_XOFF    = 10;
  localparam int C4_PDOWN   = 11;
  localparam int C4_RSV2    = 12;
  localparam int C4_RESTART = 13;
  localparam int C4_TXOFF   = 14;
  localparam int CW_DUPLEX  = 5;
  localparam int SW_XVAR    = 15;
  localparam int SW_DONE    = 6;
  localparam int SW_LINK    = 5;
  localparam int BS_DONE    = 5;
  localparam int BS_LINK    = 2;
  localparam logic [15:0] BS_FIXED_CAPS      = 16'h7808;

  // ****************************************************************
  // Reset values and timing.
  // ****************************************************************
  localparam logic [15:0] BC_RESET           = 16'h3120;
  localparam int          CLK_PERIOD_NS      = 40;
  localparam int          RESTART_HOLD_NS    = 80;
  localparam int          RESTART_HOLD_CYC   =
    (RESTART_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Carrier types.
  // ****************************************************************
  typedef struct packed {
    logic loopback;
    logic speed_100;
    logic autoneg_en;
    logic power_down;
    logic duplex_full;
    logic xover_std;
    logic xover_force;
    logic xover_off;
    logic tx_off;
    logic rsv2;
    logic rsv0;
  } p1pbc_ctrl_t;

  typedef struct packed {
    logic autoneg_done;
    logic autoneg_fail;
    logic link_up;
    logic neg_speed_100;
    logic neg_duplex_full;
  } p1pbc_phy_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [1:0]  be;
    logic        wr;
    logic        rd;
  } p1pbc_req_t;

endpackage
`default_nettype wire

// ### rtl/p1pbc_lane_merge.sv
// Byte-lane merge of write data over a register's present value.
`timescale 1ns/1ps
`default_nettype none
module p1pbc_lane_merge #(
  parameter int W = 16
) (
  // Present value and write.
  input  wire logic [W-1:0]   cur,
  input  wire logic [W-1:0]   wdata,
  input  wire logic [W/8-1:0] be,
  // Merged value.
  output logic      [W-1:0]   merged
);

  // ****************************************************************
  // Checks.
  // ****************************************************************
  if (W % 8 != 0 || W < 8)
  begin : g_bad_w
    $error("width must be a whole number of bytes");
  end

  // Each enabled lane takes the new byte, the rest keep the old one.
  for (genvar i = 0; i < W / 8; i++)
  begin : g_lane
    assign merged[8*i +: 8] = be[i] ? wdata[8*i +: 8] : cur[8*i +: 8];
  end

endmodule
`default_nettype wire

// ### rtl/p1pbc_restart_seq.sv
// Self-clearing restart sequencer for port 1 auto-negotiation.
`timescale 1ns/1ps
`default_nettype none
module p1pbc_restart_seq #(
  parameter int HOLD_CYC = p1pbc_pkg::RESTART_HOLD_CYC
) (
  // Clock, reset, enable.
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic ce,
  // Request and results.
  input  wire logic start,
  output logic      busy,
  output logic      pulse
);

  // ****************************************************************
  // Checks and state.
  // ****************************************************************
  if (HOLD_CYC < 1 || HOLD_CYC > 255)
  begin : g_bad_hold
    $error("HOLD_CYC out of range");
  end

  typedef enum logic [1:0] {
    P1PBC_RS_IDLE  = 2'b00,
    P1PBC_RS_PULSE = 2'b01,
    P1PBC_RS_HOLD  = 2'b10
  } p1pbc_rs_t;

  p1pbc_rs_t  state_ff;
  p1pbc_rs_t  nxt_state;
  logic [7:0] cnt_ff;

  // Next state: one pulse, then the bit stays set for the hold time.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      P1PBC_RS_IDLE:  if (start) nxt_state = P1PBC_RS_PULSE;
      P1PBC_RS_PULSE: nxt_state = P1PBC_RS_HOLD;
      P1PBC_RS_HOLD:  if (cnt_ff == 8'h00) nxt_state = P1PBC_RS_IDLE;
      default:        nxt_state = P1PBC_RS_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= P1PBC_RS_IDLE;
    else if (ce)
      state_ff <= nxt_state;
  end

  // Hold counter, loaded as the pulse is issued.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= 8'h00;
    else if (ce && state_ff == P1PBC_RS_PULSE)
      cnt_ff <= 8'(HOLD_CYC - 1);
    else if (ce && cnt_ff != 8'h00)
      cnt_ff <= cnt_ff - 8'h01;
  end

  assign busy  = (state_ff != P1PBC_RS_IDLE);
  assign pulse = (state_ff == P1PBC_RS_PULSE);

endmodule
`default_nettype wire

// ### tb/p1pbc_tb.sv
// Self-checking testbench for the port 1 PHY basic control and status block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************************************************************
  // Design connections and counters.
  // ****************************************************************
  logic                   clk_sys;
  logic                   reset_n;
  logic                   ce;
  p1pbc_pkg::p1pbc_req_t  host_req;
  p1pbc_pkg::p1pbc_phy_t  phy_stat;
  p1pbc_pkg::p1pbc_ctrl_t phy_ctrl;
  logic [15:0]            host_rdata_ff;
  logic                   host_rvalid_ff;
  logic                   autoneg_restart;
  logic                   eff_speed_100_ff;
  logic                   eff_duplex_full_ff;
  logic                   tx_enable_ff;
  logic [15:0]            rv;
  int                     fails;
  int                     total_checks;

  // Clock enable is driven here so that the freeze behaviour is exercised too.
  p1pbc_top i_p1pbc_top (
    .clk_sys            (clk_sys),
    .reset_n            (reset_n),
    .ce                 (ce),
    .host_req           (host_req),
    .host_rdata_ff      (host_rdata_ff),
    .host_rvalid_ff     (host_rvalid_ff),
    .phy_stat           (phy_stat),
    .phy_ctrl           (phy_ctrl),
    .autoneg_restart    (autoneg_restart),
    .eff_speed_100_ff   (eff_speed_100_ff),
    .eff_duplex_full_ff (eff_duplex_full_ff),
    .tx_enable_ff       (tx_enable_ff)
  );

  // A 40 ns clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  // Compare and count; a mismatch is reported at once.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // One-cycle write strobe of both byte lanes.
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    host_req = '{addr: a, wdata: d, be: 2'h3, wr: 1'b1, rd: 1'b0};
    @(negedge clk_sys);
    host_req.wr = 1'b0;
  endtask

  // One-cycle read strobe; the answer is awaited for a few cycles only.
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    host_req.addr = a;
    host_req.rd = 1'b1;
    @(negedge clk_sys);
    host_req.rd = 1'b0;
    while (host_rvalid_ff !== 1'b1 && n < 3)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("rvalid", 16'h0001, {15'h0000, host_rvalid_ff});
    d = host_rdata_ff;
  endtask

  // Ends the run with the counts and the verdict.
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    rd_reg(8'h4c, rv);
    chk("ctrl reset", 16'h3120, rv);
    rd_reg(8'h4e, rv);
    chk("status reset", 16'h7808, rv);
    chk("tx enable", 16'h0001, {15'h0000, tx_enable_ff});
    chk("eff speed", 16'h0000, {15'h0000, eff_speed_100_ff});
    $display("test reset done");
  endtask

  task automatic t_ctrl();
    wr_reg(8'h4c, 16'hfdff);
    rd_reg(8'h4c, rv);
    chk("ctrl ro bits", 16'h793f, rv);
    chk("ctrl flags", 16'h001f, {11'h000, phy_ctrl.loopback, phy_ctrl.power_down,
        phy_ctrl.xover_force, phy_ctrl.xover_off, phy_ctrl.tx_off});
    chk("tx off", 16'h0000, {15'h0000, tx_enable_ff});
    rd_reg(8'hc0, rv);
    chk("view four", 16'h5fc0, rv & 16'h5fc0);
    wr_reg(8'h4c, 16'h0000);
    cyc(3);
    chk("forced 10 half", 16'h0000, {14'h0000, eff_speed_100_ff, eff_duplex_full_ff});
    chk("tx on", 16'h0001, {15'h0000, tx_enable_ff});
    wr_reg(8'hc2, 16'h0020);
    wr_reg(8'hc4, 16'h8000);
    rd_reg(8'h4c, rv);
    chk("shared duplex xvar", 16'h0120, rv);
    chk("xover std", 16'h0001, {15'h0000, phy_ctrl.xover_std});
    wr_reg(8'h4c, 16'h2000);
    cyc(3);
    chk("forced 100 half", 16'h0002, {14'h0000, eff_speed_100_ff, eff_duplex_full_ff});
    $display("test control done");
  endtask

  task automatic t_restart();
    int n;
    n = 0;
    wr_reg(8'h4c, 16'h1200);
    while (autoneg_restart !== 1'b1 && n < 4)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("restart pulse", 16'h0001, {15'h0000, autoneg_restart});
    rd_reg(8'h4c, rv);
    chk("restart busy", 16'h1200, rv);
    cyc(10);
    rd_reg(8'h4c, rv);
    chk("restart cleared", 16'h1000, rv);
    wr_reg(8'hc0, 16'h2080);
    chk("restart via four", 16'h0001, {15'h0000, autoneg_restart});
    $display("test restart done");
  endtask

  task automatic t_status();
    phy_stat = '{autoneg_done: 1'b1, autoneg_fail: 1'b0, link_up: 1'b1,
                 neg_speed_100: 1'b1, neg_duplex_full: 1'b1};
    rd_reg(8'h4e, rv);
    chk("status up", 16'h782c, rv);
    cyc(2);
    chk("negotiated", 16'h0003, {14'h0000, eff_speed_100_ff, eff_duplex_full_ff});
    phy_stat = '{autoneg_done: 1'b0, autoneg_fail: 1'b1, link_up: 1'b0,
                 neg_speed_100: 1'b0, neg_duplex_full: 1'b0};
    wr_reg(8'h4c, 16'h1100);
    cyc(3);
    chk("fail duplex", 16'h0001, {15'h0000, eff_duplex_full_ff});
    rd_reg(8'h4e, rv);
    chk("status down", 16'h7808, rv);
    $display("test status done");
  endtask

  // A write while the enable is low must leave every flop as it was.
  task automatic t_freeze();
    ce = 1'b0;
    wr_reg(8'h4c, 16'h0802);
    cyc(2);
    chk("frozen", 16'h0002, {14'h0000, tx_enable_ff, phy_ctrl.power_down});
    ce = 1'b1;
    rd_reg(8'h4c, rv);
    chk("frozen ctrl", 16'h1100, rv);
    @(negedge clk_sys);
    host_req = '{addr: 8'h4c, wdata: 16'hffff, be: 2'h1, wr: 1'b1, rd: 1'b0};
    @(negedge clk_sys);
    host_req.wr = 1'b0;
    rd_reg(8'h4c, rv);
    chk("low lane", 16'h113f, rv);
    $display("test freeze done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog.
  // ****************************************************************
  initial
  begin
    fails = 0;
    total_checks = 0;
    reset_n = 1'b0;
    host_req = '0;
    phy_stat = '0;
    ce = 1'b1;
    cyc(6);
    reset_n = 1'b1;
    cyc(4);
    t_reset();
    t_ctrl();
    t_restart();
    t_status();
    t_freeze();
    test_done();
  end

  // The tests need under a hundred cycles; this limit is far beyond that.
  initial
  begin
    #200000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
